/* tx_hdlc_pkg.sv */
// Constants for the transmit HDLC message controller.
// Assumes a single 50 MHz clock domain and word-indexed register map.
package tx_hdlc_pkg;
   localparam logic [7:0] IDX_BLOCK_IRQ_EN = 8'h00;
   localparam logic [7:0] IDX_IRQ_CLR_MODE = 8'h05;
   localparam logic [7:0] IDX_LINK_STATUS  = 8'h06;
   localparam logic [7:0] IDX_LINK_IRQ_EN  = 8'h07;
   localparam logic [7:0] IDX_LINK_TX_CTL  = 8'h13;
   localparam logic [7:0] IDX_TX_BYTE_CNT  = 8'h14;
   localparam logic [7:0] IDX_BOS_BYTE_CNT = 8'h15;
   localparam int CTL_MSG_EN    = 0;
   localparam int CTL_FCS_INS   = 1;
   localparam int CTL_IDLE_INS  = 2;
   localparam int CTL_ABORT     = 3;
   localparam int CTL_MOS_ABORT = 6;
   localparam int STAT_SOT      = 6;
   localparam int STAT_EOT      = 4;
   localparam int BLOCK_IRQ_ENABLE_HDLC     = 3;
   localparam int ICR_RUR       = 0;
   localparam logic [7:0]  CTL_MASK     = 8'h4f;
   localparam logic [7:0]  STAT_MASK    = 8'h50;
   localparam logic [7:0]  REG_RESET    = 8'h00;
   localparam logic [7:0]  FLAG_OCTET   = 8'h7e;
   localparam logic [7:0]  ABORT_OCTET  = 8'hfe;
   localparam logic [7:0]  MARK_OCTET   = 8'hff;
   localparam logic [15:0] CRC_PRESET   = 16'hffff;
   localparam logic [15:0] CRC_POLY_REF = 16'h8408;
   localparam logic [2:0]  STUFF_RUN    = 3'h5;
   localparam logic [3:0]  OCTET_BITS   = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FRAME = 3'b001,
      ST_HOLD  = 3'b010,
      ST_FCS1  = 3'b011,
      ST_FCS2  = 3'b100,
      ST_ABORT = 3'b101,
      ST_BOS   = 3'b110
   } tx_state_t;
endpackage

/* tx_bit_shifter.sv */
// Octet serialiser with zero insertion and running FCS.
// Assumes BIT_EN is a one-cycle pulse per data link bit slot.
`timescale 1ns/1ps
module tx_bit_shifter
   import tx_hdlc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       bit_en,
   input  wire logic       load,
   input  wire logic [7:0] load_byte,
   input  wire logic       load_stuff,
   input  wire logic       load_crc,
   input  wire logic       crc_init,
   output logic            empty,
   output logic            bit_out,
   output logic [15:0]     crc
);
   logic [7:0]  sh_r;
   logic [3:0]  left_r;
   logic [2:0]  ones_r;
   logic        stuff_r;
   logic        crc_on_r;
   logic [15:0] crc_r;
   logic        out_r;
   logic        stuff_now;

   assign stuff_now = stuff_r && (ones_r == STUFF_RUN);
   assign empty     = (left_r == 4'h0) && !stuff_now;
   assign bit_out   = out_r;
   assign crc       = crc_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sh_r     <= 8'h00;
         left_r   <= 4'h0;
         ones_r   <= 3'h0;
         stuff_r  <= 1'b0;
         crc_on_r <= 1'b0;
         out_r    <= 1'b1;
      end else if (load) begin
         sh_r     <= load_byte;
         left_r   <= OCTET_BITS;
         stuff_r  <= load_stuff;
         crc_on_r <= load_crc;
         if (!load_stuff) begin
            ones_r <= 3'h0;
         end
      end else if (bit_en) begin
         if (stuff_now) begin
            out_r  <= 1'b0;
            ones_r <= 3'h0;
         end else if (left_r != 4'h0) begin
            out_r  <= sh_r[0];
            sh_r   <= {1'b0, sh_r[7:1]};
            left_r <= left_r - 4'h1;
            ones_r <= sh_r[0] ? ones_r + 3'h1 : 3'h0;
         end else begin
            out_r <= 1'b1;
         end
      end
   end

   // LSB-first CRC over protected bits only, stuffed zeros excluded
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crc_r <= CRC_PRESET;
      end else if (crc_init) begin
         crc_r <= CRC_PRESET;
      end else if (bit_en && !load && crc_on_r && !stuff_now && left_r != 4'h0) begin
         crc_r <= (crc_r >> 1) ^ ((crc_r[0] ^ sh_r[0]) ? CRC_POLY_REF : 16'h0000);
      end
   end
endmodule

/* tx_hdlc_message_control.sv */
// Transmit HDLC message controller: register file, framing state machine and interrupt.
// Assumes an Avalon-MM master on CLK, a buffer read port that answers BUF_DATA
// combinationally for BUF_ADDR, and LINK_BIT_EN pulses from the framer on CLK.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module tx_hdlc_message_control
   import tx_hdlc_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [9:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   output logic [31:0]      READDATA,
   output logic             WAITREQUEST,
   output logic             IRQ,
   input  wire logic        LINK_BIT_EN,
   output logic             LINK_BIT,
   output logic [6:0]       BUF_ADDR,
   input  wire logic [7:0]  BUF_DATA,
   output logic             MSG_MODE,
   output logic             TX_BUSY
);
   logic [7:0]  block_irq_enable_r;
   logic [7:0]  irq_clear_mode_control_r;
   logic [7:0]  link_status_r;
   logic [7:0]  link_irq_enable_r;
   logic [7:0]  link_tx_control_r;
   logic [6:0]  tx_link_byte_count_r;
   logic [6:0]  bos_byte_count_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic        req;
   logic        wr_do;
   logic        rd_do;
   logic [7:0]  idx;
   logic [7:0]  wd;
   logic [7:0]  rd_mux;

   tx_state_t   st_r;
   tx_state_t   st_nxt;
   logic [6:0]  oct_r;
   logic [6:0]  oct_nxt;
   logic [6:0]  count_r;
   logic        start_pend_r;
   logic        irq_r;

   logic        sh_empty;
   logic        sh_load;
   logic [7:0]  sh_byte;
   logic        sh_stuff;
   logic        sh_crc;
   logic        crc_init;
   logic [15:0] crc;
   logic        abort_clr;
   logic        eot_set;
   logic        sot_set;
   logic        take_start;
   logic        bos_dec;
   logic        ctl_wr;
   logic [7:0]  idle_octet;

   logic        msg_en;
   logic        fcs_ins;
   logic        idle_ins;
   logic        abort_req;
   logic        mos_abort_off;

   assign msg_en        = link_tx_control_r[CTL_MSG_EN];
   assign fcs_ins       = link_tx_control_r[CTL_FCS_INS];
   assign idle_ins      = link_tx_control_r[CTL_IDLE_INS];
   assign abort_req     = link_tx_control_r[CTL_ABORT];
   assign mos_abort_off = link_tx_control_r[CTL_MOS_ABORT];

   // Bus slave: one wait state, effects at the cycle that answers
   assign req         = READ | WRITE;
   assign WAITREQUEST = req & ~ack_r;
   assign wr_do       = WRITE & ack_r;
   assign rd_do       = READ & ack_r;
   assign idx         = ADDRESS[9:2];
   assign wd          = WRITEDATA[7:0];
   assign READDATA    = rdata_r;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   always_comb begin
      unique case (idx)
         IDX_BLOCK_IRQ_EN: rd_mux = block_irq_enable_r;
         IDX_IRQ_CLR_MODE: rd_mux = irq_clear_mode_control_r;
         IDX_LINK_STATUS:  rd_mux = link_status_r;
         IDX_LINK_IRQ_EN:  rd_mux = link_irq_enable_r;
         IDX_LINK_TX_CTL:  rd_mux = link_tx_control_r;
         IDX_TX_BYTE_CNT:  rd_mux = {1'b0, tx_link_byte_count_r};
         IDX_BOS_BYTE_CNT: rd_mux = {1'b0, bos_byte_count_r};
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdata_r <= 32'h00000000;
      end else if (READ && !ack_r) begin
         rdata_r <= {24'h000000, rd_mux};
      end
   end

   // Plain read/write registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         block_irq_enable_r       <= REG_RESET;
         irq_clear_mode_control_r <= REG_RESET;
         link_irq_enable_r        <= REG_RESET;
         tx_link_byte_count_r     <= 7'h00;
      end else if (wr_do) begin
         unique case (idx)
            IDX_BLOCK_IRQ_EN: block_irq_enable_r       <= wd;
            IDX_IRQ_CLR_MODE: irq_clear_mode_control_r <= wd;
            IDX_LINK_IRQ_EN:  link_irq_enable_r        <= wd;
            IDX_TX_BYTE_CNT:  tx_link_byte_count_r     <= wd[6:0];
            default:          ;
         endcase
      end
   end

   // Control register; abort bit is cleared by hardware once taken
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         link_tx_control_r <= REG_RESET;
      end else if (wr_do && idx == IDX_LINK_TX_CTL) begin
         link_tx_control_r <= wd & CTL_MASK;
      end else if (abort_clr) begin
         link_tx_control_r[CTL_ABORT] <= 1'b0;
      end
   end

   // Start request: writing the mode bit as one kicks off a message;
   // a write that also requests an abort is an abort only, so idle follows it
   assign ctl_wr     = wr_do && idx == IDX_LINK_TX_CTL;
   assign sot_set    = ctl_wr && wd[CTL_MSG_EN] && !wd[CTL_ABORT];
   assign idle_octet = idle_ins ? FLAG_OCTET : MARK_OCTET;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         start_pend_r <= 1'b0;
      end else if (sot_set) begin
         start_pend_r <= 1'b1;
      end else if (take_start || (ctl_wr && !wd[CTL_MSG_EN])) begin
         // Leaving message mode drops a start not yet taken
         start_pend_r <= 1'b0;
      end
   end

   // Bit-oriented byte count, consumed one per bit-oriented octet
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bos_byte_count_r <= 7'h00;
      end else if (wr_do && idx == IDX_BOS_BYTE_CNT) begin
         bos_byte_count_r <= wd[6:0];
      end else if (bos_dec) begin
         bos_byte_count_r <= bos_byte_count_r - 7'h01;
      end
   end

   // Status: events set, read clears when selected, write-one clears; set wins
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         link_status_r <= REG_RESET;
      end else begin
         link_status_r <= (link_status_r
                           & ~((rd_do && idx == IDX_LINK_STATUS && irq_clear_mode_control_r[ICR_RUR])
                               ? STAT_MASK : 8'h00)
                           & ~((wr_do && idx == IDX_LINK_STATUS) ? (wd & STAT_MASK) : 8'h00))
                          | {1'b0, sot_set, 1'b0, eot_set, 4'h0};
      end
   end

   // Level interrupt, one cycle behind status and enables
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= block_irq_enable_r[BLOCK_IRQ_ENABLE_HDLC]
                  & |(link_status_r & link_irq_enable_r & STAT_MASK);
      end
   end
   assign IRQ = irq_r;

   // Framing state machine; decisions are made at octet boundaries
   always_comb begin
      st_nxt     = st_r;
      oct_nxt    = oct_r;
      sh_load    = 1'b0;
      sh_byte    = FLAG_OCTET;
      sh_stuff   = 1'b0;
      sh_crc     = 1'b0;
      crc_init   = 1'b0;
      abort_clr  = 1'b0;
      eot_set    = 1'b0;
      take_start = 1'b0;
      bos_dec    = 1'b0;
      if (sh_empty) begin
         unique case (st_r)
            ST_IDLE: begin
               abort_clr = abort_req;
               if (!msg_en) begin
                  st_nxt = ST_BOS;
               end else if (start_pend_r) begin
                  sh_load    = 1'b1;
                  crc_init   = 1'b1;
                  take_start = 1'b1;
                  oct_nxt    = 7'h00;
                  st_nxt     = ST_FRAME;
               end else begin
                  sh_load = 1'b1;
                  sh_byte = idle_octet;
               end
            end
            ST_FRAME, ST_HOLD, ST_FCS1: begin
               // Abort and mode switch act only at an octet boundary; buffer pointer rewinds
               if (abort_req) begin
                  sh_load   = 1'b1;
                  sh_byte   = ABORT_OCTET;
                  abort_clr = 1'b1;
                  oct_nxt   = 7'h00;
                  st_nxt    = ST_ABORT;
               end else if (!msg_en) begin
                  oct_nxt = 7'h00;
                  if (mos_abort_off) begin
                     st_nxt = ST_BOS;
                  end else begin
                     sh_load = 1'b1;
                     sh_byte = ABORT_OCTET;
                     st_nxt  = ST_ABORT;
                  end
               end else if (st_r == ST_FCS1) begin
                  sh_load  = 1'b1;
                  sh_stuff = 1'b1;
                  sh_byte  = ~crc[15:8];
                  st_nxt   = ST_FCS2;
               end else if (st_r == ST_HOLD) begin
                  // Frame held open between blocks: flags fill the gap, CRC kept
                  if (start_pend_r) begin
                     take_start = 1'b1;
                     oct_nxt    = 7'h00;
                     st_nxt     = ST_FRAME;
                  end else begin
                     sh_load = 1'b1;
                  end
               end else if (oct_r < count_r) begin
                  sh_load  = 1'b1;
                  sh_byte  = BUF_DATA;
                  sh_stuff = 1'b1;
                  sh_crc   = 1'b1;
                  oct_nxt  = oct_r + 7'h01;
               end else begin
                  // Block end: FCS if enabled and closing flag, or hold the frame open
                  eot_set = 1'b1;
                  sh_load = 1'b1;
                  if (!idle_ins) begin
                     st_nxt = ST_HOLD;
                  end else if (fcs_ins) begin
                     sh_stuff = 1'b1;
                     sh_byte  = ~crc[7:0];
                     st_nxt   = ST_FCS1;
                  end else begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
            ST_FCS2: begin
               sh_load = 1'b1;
               st_nxt  = ST_IDLE;
            end
            ST_ABORT: begin
               st_nxt = msg_en ? ST_IDLE : ST_BOS;
            end
            ST_BOS: begin
               // Bit-oriented content is all-ones octets here
               abort_clr = abort_req;
               if (msg_en && bos_byte_count_r == 7'h00) begin
                  st_nxt = ST_IDLE;
               end else begin
                  sh_load = 1'b1;
                  sh_byte = MARK_OCTET;
                  bos_dec = bos_byte_count_r != 7'h00;
               end
            end
            default: begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_r  <= ST_IDLE;
         oct_r <= 7'h00;
      end else begin
         st_r  <= st_nxt;
         oct_r <= oct_nxt;
      end
   end

   // Byte count is latched when a block starts
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count_r <= 7'h00;
      end else if (take_start) begin
         count_r <= tx_link_byte_count_r;
      end
   end

   assign BUF_ADDR = oct_r;
   assign MSG_MODE = msg_en;
   assign TX_BUSY  = st_r != ST_IDLE && st_r != ST_BOS;

   tx_bit_shifter u_shifter (
      .clk       (CLK),
      .rst_n     (RST_N),
      .bit_en    (LINK_BIT_EN),
      .load      (sh_load),
      .load_byte (sh_byte),
      .load_stuff(sh_stuff),
      .load_crc  (sh_crc),
      .crc_init  (crc_init),
      .empty     (sh_empty),
      .bit_out   (LINK_BIT),
      .crc       (crc)
   );
endmodule

/* tx_hdlc_properties.sv */
// Port-level assertions for the transmit HDLC message controller.
// Assumes one clock domain and the one-wait-state Avalon-MM answer.
`timescale 1ns/1ps
module tx_hdlc_properties
   import tx_hdlc_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [9:0]  ADDRESS,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [31:0] READDATA,
   input wire logic        WAITREQUEST,
   input wire logic        IRQ,
   input wire logic        LINK_BIT_EN,
   input wire logic        LINK_BIT,
   input wire logic        MSG_MODE,
   input wire logic        TX_BUSY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic wr_ok;
   logic ctl_wr;
   logic bier3_r;
   assign wr_ok  = WRITE && !WAITREQUEST;
   assign ctl_wr = wr_ok && ADDRESS[9:2] == IDX_LINK_TX_CTL;
   // Shadow of the block-level interrupt gate
   always_ff @(posedge CLK) begin
      if (!RST_N)
         bier3_r <= 1'b0;
      else if (wr_ok && ADDRESS[9:2] == IDX_BLOCK_IRQ_EN)
         bier3_r <= WRITEDATA[BLOCK_IRQ_ENABLE_HDLC];
   end
   chk_wait_one: assert property (($rose(READ) || $rose(WRITE)) |-> WAITREQUEST ##1 !WAITREQUEST)
      else $error("request not answered after one wait state");
   chk_idle_nowait: assert property (!(READ || WRITE) |-> !WAITREQUEST)
      else $error("wait request without a request");
   chk_mode_copy: assert property (ctl_wr |=> MSG_MODE == $past(WRITEDATA[CTL_MSG_EN]))
      else $error("mode output does not follow control write");
   chk_irq_gate: assert property (!bier3_r |=> !IRQ)
      else $error("interrupt raised while block gate is off");
   chk_link_hold: assert property (!LINK_BIT_EN |=> $stable(LINK_BIT))
      else $error("link bit changed without a bit slot");
   chk_unmapped_zero: assert property (READ && !WAITREQUEST && ADDRESS[9:2] == 8'h30 |-> READDATA == 32'h0)
      else $error("unmapped read not zero");
   chk_ctl_reserved: assert property (READ && !WAITREQUEST && ADDRESS[9:2] == IDX_LINK_TX_CTL
                                      |-> (READDATA & ~{24'h0, CTL_MASK}) == 32'h0)
      else $error("reserved control bits read nonzero");
   chk_start_busy: assert property (ctl_wr && WRITEDATA[CTL_MSG_EN] && !WRITEDATA[CTL_ABORT] && !MSG_MODE
                                    |-> ##[1:400] TX_BUSY)
      else $error("message did not start");
   cover property (IRQ ##1 !IRQ);
   cover property (TX_BUSY ##1 !TX_BUSY);
   cover property (ctl_wr && WRITEDATA[CTL_ABORT]);
endmodule
bind tx_hdlc_message_control tx_hdlc_properties u_props (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
   .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
   .IRQ(IRQ), .LINK_BIT_EN(LINK_BIT_EN), .LINK_BIT(LINK_BIT), .MSG_MODE(MSG_MODE), .TX_BUSY(TX_BUSY));

/* link_far_end.sv */
// Far end of the data link: bit slot pacing, transmit buffer and an HDLC receiver.
// Assumes LINK_BIT is updated at the edge where LINK_BIT_EN is high.
`timescale 1ns/1ps
module link_far_end (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       LINK_BIT,
   input  wire logic [6:0] BUF_ADDR,
   output logic            LINK_BIT_EN,
   output logic [7:0]      BUF_DATA
);
   int   gap_r = 4;
   int   cnt_r, ones_r, frames, aborts, flags, last_bytes;
   logic en_d_r;
   logic [15:0] last_res;
   logic q[$];
   // Odd octets are all ones so that zero insertion is exercised
   assign BUF_DATA = BUF_ADDR[0] ? 8'hff : {1'b0, BUF_ADDR} ^ 8'h3c;
   initial LINK_BIT_EN = 1'b0;
   task automatic take(input logic b);
      logic [15:0] crc;
      logic fb;
      crc = 16'hffff;
      if (b) begin
         ones_r++;
         if (ones_r >= 7) begin
            if (ones_r == 7 && q.size() >= 15)
               aborts++;
            q.delete();
            return;
         end
      end else if (ones_r == 5) begin
         ones_r = 0;
         return;
      end else if (ones_r == 6) begin
         ones_r = 0;
         flags++;
         repeat (7) void'(q.pop_back());
         if (q.size() >= 16) begin
            foreach (q[i]) begin
               fb = crc[0] ^ q[i];
               crc = crc >> 1;
               if (fb)
                  crc = crc ^ 16'h8408;
            end
            last_bytes = (q.size() % 8 == 0) ? q.size() / 8 : -1;
            last_res = crc;
            frames++;
         end
         q.delete();
         return;
      end else
         ones_r = 0;
      q.push_back(b);
   endtask
   always @(posedge CLK) begin
      if (!RST_N) begin
         cnt_r <= 0;
         LINK_BIT_EN <= 1'b0;
         en_d_r <= 1'b0;
      end else begin
         LINK_BIT_EN <= (cnt_r == 0);
         cnt_r <= (cnt_r == 0) ? gap_r - 1 : cnt_r - 1;
         en_d_r <= LINK_BIT_EN;
         if (en_d_r)
            take(LINK_BIT);
      end
   end
endmodule

/* tb_tx_hdlc_message_control.sv */
// Self-checking bench for the transmit HDLC message controller.
// Assumes the far-end model decodes frames and aborts from LINK_BIT.
`timescale 1ns/1ps
module tb_tx_hdlc_message_control;
   import tx_hdlc_pkg::*;
   logic        CLK, RST_N, READ, WRITE, WAITREQUEST, IRQ, LINK_BIT_EN, LINK_BIT, MSG_MODE, TX_BUSY;
   logic [9:0]  ADDRESS;
   logic [31:0] WRITEDATA, READDATA;
   logic [6:0]  BUF_ADDR;
   logic [7:0]  BUF_DATA, rd;
   logic [7:0]  idxs [8] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h13, 8'h14, 8'h15, 8'h30};
   int          errors, tests_run, f0, a0, g0;
`define CHK(a, e) \
   begin \
      tests_run++; \
      if ((a) !== (e)) begin \
         errors++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
   tx_hdlc_message_control dut (.CLK, .RST_N, .ADDRESS, .READ, .WRITE, .WRITEDATA, .READDATA, .WAITREQUEST,
      .IRQ, .LINK_BIT_EN, .LINK_BIT, .BUF_ADDR, .BUF_DATA, .MSG_MODE, .TX_BUSY);
   link_far_end far (.CLK, .RST_N, .LINK_BIT, .BUF_ADDR, .LINK_BIT_EN, .BUF_DATA);
   always #10 CLK = ~CLK;
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge CLK);
      ADDRESS   <= {idx, 2'b00};
      WRITEDATA <= {24'h0, wd};
      WRITE     <= wr;
      READ      <= !wr;
      @(posedge CLK);
      while (WAITREQUEST !== 1'b0)
         @(posedge CLK);
      rd = READDATA[7:0];
      WRITE <= 1'b0;
      READ  <= 1'b0;
   endtask
   task automatic close_out();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge CLK);
      errors++;
      close_out();
   end
   initial begin
      CLK = 1'b0; RST_N = 1'b0; READ = 1'b0; WRITE = 1'b0; ADDRESS = '0; WRITEDATA = '0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      foreach (idxs[i]) begin
         acc(1'b0, idxs[i], 8'h00);
         `CHK(rd, 8'h00)
      end
      acc(1'b1, 8'h13, 8'hb0);
      acc(1'b0, 8'h13, 8'h00);
      `CHK(rd, 8'h00)
      acc(1'b1, 8'h00, 8'h08);
      acc(1'b1, 8'h07, 8'h50);
      acc(1'b1, 8'h05, 8'h01);
      acc(1'b1, 8'h14, 8'h04);
      f0 = far.frames;
      acc(1'b1, 8'h13, 8'h07);
      repeat (3) @(posedge CLK);
      `CHK(IRQ, 1'b1)
      for (int i = 0; i < 3000 && far.frames == f0; i++) @(posedge CLK);
      `CHK(far.last_bytes, 6)
      `CHK(far.last_res, 16'hf0b8)
      acc(1'b0, 8'h06, 8'h00);
      `CHK(rd & STAT_MASK, 8'h50)
      repeat (3) @(posedge CLK);
      `CHK(IRQ, 1'b0)
      acc(1'b0, 8'h06, 8'h00);
      `CHK(rd & STAT_MASK, 8'h00)
      g0 = far.flags;
      repeat (300) @(posedge CLK);
      `CHK(far.flags > g0 + 5, 1'b1)
      acc(1'b1, 8'h00, 8'h00);
      acc(1'b1, 8'h05, 8'h00);
      acc(1'b1, 8'h14, 8'h03);
      far.gap_r <= 7;
      f0 = far.frames;
      acc(1'b1, 8'h13, 8'h05);
      for (int i = 0; i < 3000 && far.frames == f0; i++) @(posedge CLK);
      `CHK(far.last_bytes, 3)
      `CHK(IRQ, 1'b0)
      acc(1'b0, 8'h06, 8'h00);
      acc(1'b0, 8'h06, 8'h00);
      `CHK(rd & STAT_MASK, 8'h50)
      acc(1'b1, 8'h06, 8'h50);
      acc(1'b0, 8'h06, 8'h00);
      `CHK(rd & STAT_MASK, 8'h00)
      far.gap_r <= 4;
      acc(1'b1, 8'h14, 8'h28);
      a0 = far.aborts;
      f0 = far.frames;
      acc(1'b1, 8'h13, 8'h07);
      for (int i = 0; i < 3000 && !(TX_BUSY && BUF_ADDR >= 7'd2); i++) @(posedge CLK);
      acc(1'b1, 8'h13, 8'h0f);
      for (int i = 0; i < 600 && far.aborts == a0; i++) @(posedge CLK);
      `CHK(far.aborts, a0 + 1)
      acc(1'b0, 8'h13, 8'h00);
      `CHK(rd[CTL_ABORT], 1'b0)
      g0 = far.flags;
      repeat (300) @(posedge CLK);
      `CHK(far.flags > g0 + 5, 1'b1)
      `CHK(far.frames, f0)
      acc(1'b1, 8'h13, 8'h07);
      for (int i = 0; i < 3000 && !(TX_BUSY && BUF_ADDR >= 7'd2); i++) @(posedge CLK);
      a0 = far.aborts;
      acc(1'b1, 8'h13, 8'h00);
      for (int i = 0; i < 600 && far.aborts == a0; i++) @(posedge CLK);
      `CHK(far.aborts, a0 + 1)
      `CHK(MSG_MODE, 1'b0)
      // Mode switch with the abort suppressed: frame ends at the next octet boundary
      acc(1'b1, 8'h13, 8'h47);
      for (int i = 0; i < 3000 && !(TX_BUSY && BUF_ADDR >= 7'd2); i++) @(posedge CLK);
      f0 = far.frames;
      acc(1'b1, 8'h13, 8'h40);
      for (int i = 0; i < 48 && TX_BUSY; i++) @(posedge CLK);
      `CHK(TX_BUSY, 1'b0)
      `CHK(far.frames, f0)
      `CHK(MSG_MODE, 1'b0)
      close_out();
   end
endmodule
